// File: design/fpps_grp.sv
// Issue group picker and functional-unit router for one fetch packet
`include "fpps_map.svh"
module fpps_grp (
	input wire logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] pkt_i,
	input wire logic [`FPPS_SLOTS-1:0] pend_i,
	output logic [`FPPS_SLOTS-1:0] grp_o,
	output logic [`FPPS_SLOTS-1:0] rest_o,
	output logic [`FPPS_SLOTS-1:0] unit_v_o,
	output logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] unit_ins_o
);
	import fpps_pkg::*;

	always_comb begin
		logic open;
		logic [2:0] uidx;
		open = 1'b1;
		uidx = 3'h0;
		grp_o = '0;
		unit_v_o = '0;
		unit_ins_o = '0;
		// First pending slot opens the group; a clear parallel bit ends it
		for (int k = 0; k < `FPPS_SLOTS; k++) begin
			if (pend_i[k] && open) begin
				grp_o[k] = 1'b1; // RULE22
				open = pkt_i[k][`FPPS_PBIT];
			end
		end
		rest_o = pend_i & ~grp_o;
		// Lowest slot wins a unit clash
		for (int k = `FPPS_SLOTS - 1; k >= 0; k--) begin
			uidx = pkt_i[k][`FPPS_UNIT_HI:`FPPS_UNIT_LO];
			if (grp_o[k] && pkt_i[k][`FPPS_CLS_HI:`FPPS_CLS_LO] != CLS_NO_OPERATION) begin // RULE23
				unit_v_o[uidx] = 1'b1; // RULE5
				unit_ins_o[uidx] = pkt_i[k];
			end
		end
	end
endmodule

// File: design/fpps_lane.sv
// One functional-unit lane: decode and execute-phase tracking
`include "fpps_map.svh"
module fpps_lane (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic dec_load_i,
	input wire logic [`FPPS_IW-1:0] instr_i,
	input wire logic pred_i,
	input wire logic sat_i,
	output logic dec_v_o,
	output logic [`FPPS_IW-1:0] dec_instr_o,
	output logic x1_v_o,
	output logic addr_gen_o,
	output logic rf_wr_x1_o,
	output logic rf_wr_x2_o,
	output logic rf_wr_x4_o,
	output logic rf_wr_x5_o,
	output logic send_o,
	output logic store_o,
	output logic access_o,
	output logic ld_ret_o,
	output logic sat_set_o,
	output logic branch_o
);
	import fpps_pkg::*;

	fpps_pkg::fpps_cls_t dec_cls;
	logic dec_v_q;
	logic [`FPPS_IW-1:0] dec_ins_q;
	logic x1_v_q, x1_ls_q, x1_wr_q, x1_br_q, x1_sgl_q, x1_m16_q, x1_mx_q, x1_ld_q, x1_st_q;
	logic live;
	logic x2_m16_q, x2_mx_q, x2_ld_q, send_q, store_q, sat2_q;
	logic x3_mx_q, x3_ld_q, acc_q, sat3_q;
	logic ret_q, wr4_q, wr5_q;

	assign dec_cls = fpps_cls_t'(dec_ins_q[`FPPS_CLS_HI:`FPPS_CLS_LO]);
	assign live = x1_v_q & pred_i; // RULE18

	// Decode held inside the unit one cycle before execution
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			dec_v_q <= 1'b0; // RULE24
			dec_ins_q <= '0;
		end else begin
			dec_v_q <= dec_load_i; // RULE6
			dec_ins_q <= instr_i;
		end
	end

	// Class of the instruction in its first execute phase
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			{x1_v_q, x1_ls_q, x1_wr_q, x1_br_q, x1_sgl_q} <= 5'h00;
			{x1_m16_q, x1_mx_q, x1_ld_q, x1_st_q} <= 4'h0;
		end else begin
			x1_v_q <= dec_v_q; // RULE7
			x1_ls_q <= dec_v_q && (dec_cls == CLS_LOAD || dec_cls == CLS_STORE); // RULE8
			x1_wr_q <= dec_v_q && (dec_cls == CLS_SINGLE || dec_cls == CLS_LOAD
				|| dec_cls == CLS_STORE); // RULE10
			x1_br_q <= dec_v_q && dec_cls == CLS_BRANCH;
			x1_sgl_q <= dec_v_q && dec_cls == CLS_SINGLE;
			x1_m16_q <= dec_v_q && dec_cls == CLS_MUL16;
			x1_mx_q <= dec_v_q && dec_cls == CLS_MULX;
			x1_ld_q <= dec_v_q && dec_cls == CLS_LOAD;
			x1_st_q <= dec_v_q && dec_cls == CLS_STORE;
		end
	end

	// Later phases carry only what survived the predicate
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			{x2_m16_q, x2_mx_q, x2_ld_q, send_q, store_q, sat2_q} <= 6'h00;
			{x3_mx_q, x3_ld_q, acc_q, sat3_q} <= 4'h0;
			{ret_q, wr4_q, wr5_q} <= 3'h0;
		end else begin
			x2_m16_q <= live & x1_m16_q; // RULE25
			x2_mx_q <= live & x1_mx_q;
			x2_ld_q <= live & x1_ld_q;
			send_q <= live & (x1_ld_q | x1_st_q); // RULE11
			store_q <= live & x1_st_q;
			sat2_q <= live & x1_sgl_q & sat_i; // RULE12
			acc_q <= send_q; // RULE14
			x3_ld_q <= x2_ld_q;
			x3_mx_q <= x2_mx_q;
			sat3_q <= (x2_m16_q | x2_mx_q) & sat_i; // RULE15
			ret_q <= x3_ld_q; // RULE16
			wr4_q <= x3_mx_q;
			wr5_q <= ret_q; // RULE17
		end
	end

	assign dec_v_o = dec_v_q;
	assign dec_instr_o = dec_ins_q;
	assign x1_v_o = x1_v_q;
	assign addr_gen_o = x1_ls_q;
	assign rf_wr_x1_o = x1_wr_q & pred_i; // RULE10
	assign rf_wr_x2_o = x2_m16_q; // RULE13
	assign rf_wr_x4_o = wr4_q;
	assign rf_wr_x5_o = wr5_q;
	assign send_o = send_q;
	assign store_o = store_q;
	assign access_o = acc_q;
	assign ld_ret_o = ret_q;
	assign sat_set_o = sat2_q | sat3_q;
	assign branch_o = x1_br_q & pred_i; // RULE9
endmodule

// File: design/fpps_map.svh
// Constants of the pipeline sequencer: widths, field positions, addresses
`ifndef FPPS_MAP_SVH
`define FPPS_MAP_SVH
`define FPPS_IW 32
`define FPPS_AW 32
`define FPPS_SLOTS 8
`define FPPS_PBIT 0
`define FPPS_CLS_HI 3
`define FPPS_CLS_LO 1
`define FPPS_UNIT_HI 6
`define FPPS_UNIT_LO 4
`define FPPS_PKT_BYTES 32'h0000_0020
`define FPPS_RESET_ADDR 32'h0000_0000
`endif

// File: design/fpps_pkg.sv
// Types shared by the pipeline sequencer modules
package fpps_pkg;
	typedef enum logic [2:0] {
		CLS_NO_OPERATION = 3'h0,
		CLS_SINGLE = 3'h1,
		CLS_MUL16 = 3'h2,
		CLS_STORE = 3'h3,
		CLS_MULX = 3'h4,
		CLS_LOAD = 3'h5,
		CLS_BRANCH = 3'h6
	} fpps_cls_t;
endpackage

// File: design/fpps_seq.sv
// Eleven-phase fixed-point pipeline sequencer: fetch, dispatch, execute control
// Operation
// RULE1: Packets pass generate, send, wait, receive, dispatch, decode, execute one..five.
// RULE2: Full pipeline holds consecutive packets in consecutive phases.
// RULE3: An all-parallel packet forms exactly one issue group.
// RULE4: Address made in generate, sent in send; packet arrives in receive.
// RULE5: Dispatch picks the next issue group and routes it to units.
// RULE6: Each dispatched instruction is decoded in its unit one cycle early.
// RULE7: Execute one evaluates predicates and reads operands for all classes.
// RULE8: Loads and stores make addresses and write address updates in execute one.
// RULE9: A branch in execute one redirects the packet in generate.
// RULE10: Single-cycle results are written in execute one.
// RULE11: Execute two sends load address, or store address and data.
// RULE12: Saturating single-cycle result sets the saturation flag in execute two.
// RULE13: Short multiplies and unit non-multiplies write results in execute two.
// RULE14: Data memory access happens in execute three; stores complete.
// RULE15: Saturating multiply sets the saturation flag in execute three.
// RULE16: Load data returns and extended multiplies write in execute four.
// RULE17: Loads write returned data in execute five.
// RULE18: False predicate kills all writes and actions after execute one.
// RULE19: Every phase step coincides with one clock edge.
// RULE20: No interlocks; execution never stalls on operand dependencies.
// RULE21: A fetch packet carries eight instructions through fetch together.
// RULE22: An issue group holds one to eight instructions.
// RULE23: No-operation instructions are never routed to a unit.
// RULE24: Reset empties every phase.
// RULE25: Class and predicate outcome follow each instruction after execute one.
`include "fpps_map.svh"
module fpps_seq (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] fetch_packet_i,
	input wire logic [`FPPS_AW-1:0] branch_target_i,
	input wire logic [`FPPS_SLOTS-1:0] pred_i,
	input wire logic [`FPPS_SLOTS-1:0] sat_i,
	input wire logic sat_clr_i,
	output logic [`FPPS_AW-1:0] fetch_addr_o,
	output logic fetch_req_o,
	output logic fetch_hold_o,
	output logic dispatch_v_o,
	output logic [`FPPS_SLOTS-1:0] dec_v_o,
	output logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] dec_instr_o,
	output logic [`FPPS_SLOTS-1:0] x1_v_o,
	output logic [`FPPS_SLOTS-1:0] addr_gen_o,
	output logic [`FPPS_SLOTS-1:0] rf_wr_x1_o,
	output logic [`FPPS_SLOTS-1:0] rf_wr_x2_o,
	output logic [`FPPS_SLOTS-1:0] rf_wr_x4_o,
	output logic [`FPPS_SLOTS-1:0] rf_wr_x5_o,
	output logic [`FPPS_SLOTS-1:0] dmem_send_o,
	output logic [`FPPS_SLOTS-1:0] dmem_store_o,
	output logic [`FPPS_SLOTS-1:0] dmem_access_o,
	output logic [`FPPS_SLOTS-1:0] ld_return_o,
	output logic sat_flag_o
);
	import fpps_pkg::*;

	// Fetch phase registers
	logic [`FPPS_AW-1:0] gen_seq_q;
	logic [`FPPS_AW-1:0] gen_addr;
	logic snd_v_q, wt_v_q, rcv_v_q;
	logic [`FPPS_AW-1:0] snd_a_q, wt_a_q, rcv_a_q;

	// Dispatch phase registers
	logic dsp_v_q;
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] dsp_pkt_q;
	logic [`FPPS_SLOTS-1:0] dsp_pend_q;
	logic dsp_v_d;
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] dsp_pkt_d;
	logic [`FPPS_SLOTS-1:0] dsp_pend_d;
	logic hold_q, hold_d;

	// Group picker results, current and next
	logic [`FPPS_SLOTS-1:0] grp_cur, rest_cur, rest_nxt;
	logic [`FPPS_SLOTS-1:0] unit_v;
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] unit_ins;

	// Lane results
	logic [`FPPS_SLOTS-1:0] lane_br;
	logic [`FPPS_SLOTS-1:0] lane_sat;
	logic br_take;
	logic sat_flag_q;

	// Generate phase: a branch in execute one replaces the address made now
	assign br_take = |lane_br;
	assign gen_addr = br_take ? branch_target_i : gen_seq_q; // RULE9

	// Fetch phases step together one per clock; frozen while dispatch splits
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			gen_seq_q <= `FPPS_RESET_ADDR;
			snd_v_q <= 1'b0; // RULE24
			wt_v_q <= 1'b0;
			rcv_v_q <= 1'b0;
			snd_a_q <= '0;
			wt_a_q <= '0;
			rcv_a_q <= '0;
		end else if (!hold_q) begin
			gen_seq_q <= gen_addr + `FPPS_PKT_BYTES;
			snd_v_q <= 1'b1; // RULE1
			snd_a_q <= gen_addr; // RULE4
			wt_v_q <= snd_v_q;
			wt_a_q <= snd_a_q;
			rcv_v_q <= wt_v_q;
			rcv_a_q <= wt_a_q;
		end else begin
			gen_seq_q <= gen_addr; // RULE9
		end
	end

	// Next dispatch content: new packet from receive, or what is left of it
	always_comb begin
		dsp_v_d = dsp_v_q;
		dsp_pkt_d = dsp_pkt_q;
		dsp_pend_d = rest_cur;
		if (!hold_q) begin
			dsp_v_d = rcv_v_q; // RULE2
			dsp_pkt_d = fetch_packet_i; // RULE21
			dsp_pend_d = rcv_v_q ? '1 : '0;
		end
	end

	assign hold_d = dsp_v_d && (|rest_nxt); // RULE3

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			dsp_v_q <= 1'b0; // RULE24
			dsp_pkt_q <= '0;
			dsp_pend_q <= '0;
			hold_q <= 1'b0;
		end else begin
			dsp_v_q <= dsp_v_d; // RULE19
			dsp_pkt_q <= dsp_pkt_d; // RULE4
			dsp_pend_q <= dsp_pend_d;
			hold_q <= hold_d;
		end
	end

	// Group issued this cycle
	fpps_grp u_grp_cur (
		.pkt_i(dsp_pkt_q),
		.pend_i(dsp_pend_q),
		.grp_o(grp_cur),
		.rest_o(rest_cur),
		.unit_v_o(unit_v),
		.unit_ins_o(unit_ins)
	);

	// Lookahead so the fetch hold is a register
	fpps_grp u_grp_nxt (
		.pkt_i(dsp_pkt_d),
		.pend_i(dsp_pend_d),
		.grp_o(),
		.rest_o(rest_nxt),
		.unit_v_o(),
		.unit_ins_o()
	);

	// Lanes never stall: the fetch hold does not reach them
	for (genvar u = 0; u < `FPPS_SLOTS; u++) begin : g_lane
		fpps_lane u_lane (
			.mclk_i(mclk_i),
			.rst_i(rst_i),
			.dec_load_i(dsp_v_q & unit_v[u]), // RULE20
			.instr_i(unit_ins[u]),
			.pred_i(pred_i[u]),
			.sat_i(sat_i[u]),
			.dec_v_o(dec_v_o[u]),
			.dec_instr_o(dec_instr_o[u]),
			.x1_v_o(x1_v_o[u]),
			.addr_gen_o(addr_gen_o[u]),
			.rf_wr_x1_o(rf_wr_x1_o[u]),
			.rf_wr_x2_o(rf_wr_x2_o[u]),
			.rf_wr_x4_o(rf_wr_x4_o[u]),
			.rf_wr_x5_o(rf_wr_x5_o[u]),
			.send_o(dmem_send_o[u]),
			.store_o(dmem_store_o[u]),
			.access_o(dmem_access_o[u]),
			.ld_ret_o(ld_return_o[u]),
			.sat_set_o(lane_sat[u]),
			.branch_o(lane_br[u])
		);
	end

	// Saturation bit of the control status word; a set beats a clear
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sat_flag_q <= 1'b0;
		end else if (|lane_sat) begin
			sat_flag_q <= 1'b1; // RULE12
		end else if (sat_clr_i) begin
			sat_flag_q <= 1'b0;
		end
	end

	assign fetch_addr_o = snd_a_q;
	assign fetch_req_o = snd_v_q;
	assign fetch_hold_o = hold_q;
	assign dispatch_v_o = dsp_v_q;
	assign sat_flag_o = sat_flag_q;

	// Checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	sequence seq_fetch_run;
		snd_v_q && !hold_q ##1 wt_v_q && !hold_q ##1 rcv_v_q && !hold_q;
	endsequence

	AST_FETCH_TO_DISPATCH: assert property ( // RULE1
		seq_fetch_run |=> dsp_v_q
	) else $error("fetched packet did not reach dispatch");

	AST_SEND_STEP: assert property ( // RULE2
		snd_v_q && !hold_q |=> wt_v_q && wt_a_q == $past(snd_a_q)
	) else $error("send phase did not step into wait");

	AST_RECV_CAPTURE: assert property ( // RULE4
		rcv_v_q && !hold_q |=> dsp_v_q && dsp_pkt_q == $past(fetch_packet_i)
	) else $error("received packet not captured for dispatch");

	AST_SEQ_ADDR: assert property ( // RULE4
		!hold_q && !br_take |=> snd_a_q == $past(gen_seq_q)
			&& gen_seq_q == $past(gen_seq_q) + `FPPS_PKT_BYTES
	) else $error("sequential fetch address wrong");

	AST_BRANCH_GEN: assert property ( // RULE9
		br_take && !hold_q |=> snd_v_q && snd_a_q == $past(branch_target_i)
	) else $error("branch target not generated");

	AST_HOLD_FREEZE: assert property ( // RULE1
		hold_q |=> $stable(snd_a_q) && $stable(wt_a_q) && $stable(rcv_a_q)
			&& $stable(rcv_v_q)
	) else $error("fetch phases moved during hold");

	AST_FULL_GROUP: assert property ( // RULE3
		dsp_v_q && dsp_pend_q == '1
			&& (&{dsp_pkt_q[0][`FPPS_PBIT], dsp_pkt_q[1][`FPPS_PBIT], dsp_pkt_q[2][`FPPS_PBIT],
			dsp_pkt_q[3][`FPPS_PBIT], dsp_pkt_q[4][`FPPS_PBIT], dsp_pkt_q[5][`FPPS_PBIT],
			dsp_pkt_q[6][`FPPS_PBIT]})
			|-> grp_cur == '1 && !hold_q
	) else $error("all-parallel packet split into groups");

	AST_GROUP_NONEMPTY: assert property ( // RULE22
		dsp_v_q |-> grp_cur != '0 && (grp_cur & rest_cur) == '0
	) else $error("empty or overlapping issue group");

	AST_HOLD_RELEASE: assert property ( // RULE5
		hold_q |=> dsp_pend_q == $past(rest_cur)
	) else $error("remaining slots lost during split");

	AST_SAT_STICKY: assert property ( // RULE12
		(|lane_sat) |=> sat_flag_q
	) else $error("saturation event lost");

	AST_SAT_KEEP: assert property ( // RULE12
		!(|lane_sat) && !sat_clr_i |=> $stable(sat_flag_q)
	) else $error("saturation flag changed without cause");

	AST_SAT_CLEAR: assert property ( // RULE12
		sat_clr_i && !(|lane_sat) |=> !sat_flag_q
	) else $error("saturation flag clear lost");

	AST_RESET_EMPTY: assert property ( // RULE24
		$fell(rst_i) |-> !snd_v_q && !wt_v_q && !rcv_v_q && !dsp_v_q && !hold_q
			&& !sat_flag_q && dec_v_o == '0 && x1_v_o == '0
	) else $error("pipeline not empty after reset");

	AST_HOLD_MATCH: assert property ( // RULE5
		dsp_v_q |-> hold_q == (|rest_cur)
	) else $error("fetch hold disagrees with remaining slots");

	for (genvar u = 0; u < `FPPS_SLOTS; u++) begin : g_chk
		sequence seq_load_tail;
			dmem_send_o[u] && !dmem_store_o[u] ##1 dmem_access_o[u]
				##1 ld_return_o[u] ##1 rf_wr_x5_o[u];
		endsequence

		sequence seq_store_tail;
			dmem_send_o[u] && dmem_store_o[u] ##1 dmem_access_o[u];
		endsequence

		AST_NO_INTERLOCK: assert property ( // RULE20
			dsp_v_q && unit_v[u] |=> dec_v_o[u] ##1 x1_v_o[u]
		) else $error("routed instruction did not reach execute one");

		AST_NOP_SKIP: assert property ( // RULE23
			unit_v[u] |-> unit_ins[u][`FPPS_CLS_HI:`FPPS_CLS_LO] != CLS_NO_OPERATION
		) else $error("no-operation routed to a unit");

		AST_LOAD_PATH: assert property ( // RULE17
			x1_v_o[u] && pred_i[u] && addr_gen_o[u]
				&& !$past(dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_STORE)
				|=> seq_load_tail
		) else $error("load phases out of step");

		AST_STORE_PATH: assert property ( // RULE14
			x1_v_o[u] && pred_i[u] && addr_gen_o[u]
				&& $past(dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_STORE)
				|=> seq_store_tail ##1 !ld_return_o[u]
		) else $error("store phases out of step");

		AST_PRED_KILL: assert property ( // RULE18
			x1_v_o[u] && !pred_i[u] |=> !dmem_send_o[u] && !rf_wr_x2_o[u]
				##1 !dmem_access_o[u] ##1 !ld_return_o[u] && !rf_wr_x4_o[u]
				##1 !rf_wr_x5_o[u]
		) else $error("killed instruction acted after execute one");

		AST_MUL16_WRITE: assert property ( // RULE13
			dec_v_o[u] && dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_MUL16
				##1 pred_i[u] |=> rf_wr_x2_o[u]
		) else $error("short multiply did not write in execute two");

		AST_MULX_WRITE: assert property ( // RULE16
			dec_v_o[u] && dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_MULX
				##1 pred_i[u] |=> !rf_wr_x2_o[u] ##2 rf_wr_x4_o[u]
		) else $error("extended multiply did not write in execute four");

		AST_SINGLE_WRITE: assert property ( // RULE10
			dec_v_o[u] && dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_SINGLE
				|=> x1_v_o[u] && rf_wr_x1_o[u] == pred_i[u]
		) else $error("single-cycle write not in execute one");

		AST_SAT_SINGLE: assert property ( // RULE12
			dec_v_o[u] && dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_SINGLE
				##1 pred_i[u] && sat_i[u] ##1 1'b1 |=> sat_flag_q
		) else $error("single-cycle saturation not flagged in execute two");

		AST_SAT_MUL: assert property ( // RULE15
			dec_v_o[u] && dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_MUL16
				##1 pred_i[u] ##1 sat_i[u] ##1 1'b1 |=> sat_flag_q
		) else $error("multiply saturation not flagged in execute three");

		AST_ADDR_GEN: assert property ( // RULE8
			addr_gen_o[u] |-> x1_v_o[u] && (rf_wr_x1_o[u] == pred_i[u])
		) else $error("address phase not in execute one");

		AST_SAT_MULX: assert property ( // RULE15
			dec_v_o[u] && dec_instr_o[u][`FPPS_CLS_HI:`FPPS_CLS_LO] == CLS_MULX
				##1 pred_i[u] ##1 sat_i[u] ##1 1'b1 |=> sat_flag_q
		) else $error("extended multiply saturation not flagged in execute three");

		AST_KILL_X1: assert property ( // RULE18
			x1_v_o[u] && !pred_i[u] |-> !rf_wr_x1_o[u] && !lane_br[u]
		) else $error("killed instruction wrote or branched in execute one");
	end
endmodule

// File: verif/fpps_pmem.sv
// Program memory model answering the sequencer's fetch link
`include "fpps_map.svh"
module fpps_pmem (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [`FPPS_AW-1:0] fetch_addr_i,
	input wire logic fetch_req_i,
	input wire logic fetch_hold_i,
	output logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] fetch_packet_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] prog [64];
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] last_q;
	logic wait_v_q;
	logic recv_v_q;
	logic [`FPPS_AW-1:0] wait_a_q;
	logic [`FPPS_AW-1:0] recv_a_q;
	// Access in wait phase, packet shown in receive phase, frozen while held
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wait_v_q <= 1'b0;
			recv_v_q <= 1'b0;
		end else if (!fetch_hold_i) begin
			wait_v_q <= fetch_req_i;
			wait_a_q <= fetch_addr_i;
			recv_v_q <= wait_v_q;
			recv_a_q <= wait_a_q;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			last_q <= '0;
		end else begin
			last_q <= fetch_packet_o;
		end
	end
	// Outside receive the bus toggles, inverting its last value every cycle
	always_comb begin
		if (recv_v_q) begin
			fetch_packet_o = prog[recv_a_q[10:5]];
		end else begin
			fetch_packet_o = ~last_q;
		end
	end
endmodule

// File: verif/tb_fixed_point_pipeline_sequencer.sv
// Self-checking bench of the pipeline sequencer
`include "fpps_map.svh"
module tb_fixed_point_pipeline_sequencer;
	import fpps_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] fetch_packet_i;
	logic [`FPPS_AW-1:0] branch_target_i = 32'h0000_0100;
	logic [`FPPS_SLOTS-1:0] pred_i = 8'hff;
	logic [`FPPS_SLOTS-1:0] sat_i = 8'h00;
	logic sat_clr_i = 1'b0;
	logic [`FPPS_AW-1:0] fetch_addr_o;
	logic fetch_req_o, fetch_hold_o, dispatch_v_o, sat_flag_o;
	logic [`FPPS_SLOTS-1:0] dec_v_o, x1_v_o, addr_gen_o, rf_wr_x1_o, rf_wr_x2_o;
	logic [`FPPS_SLOTS-1:0] rf_wr_x4_o, rf_wr_x5_o, dmem_send_o, dmem_store_o;
	logic [`FPPS_SLOTS-1:0] dmem_access_o, ld_return_o;
	logic [`FPPS_SLOTS-1:0][`FPPS_IW-1:0] dec_instr_o;
	int err_count = 0;
	int total_checks = 0;
	int cyc_count = 0;
	fpps_seq i_fpps_seq (.mclk_i(mclk_i), .rst_i(rst_i), .fetch_packet_i(fetch_packet_i),
		.branch_target_i(branch_target_i), .pred_i(pred_i), .sat_i(sat_i),
		.sat_clr_i(sat_clr_i), .fetch_addr_o(fetch_addr_o), .fetch_req_o(fetch_req_o),
		.fetch_hold_o(fetch_hold_o), .dispatch_v_o(dispatch_v_o), .dec_v_o(dec_v_o),
		.dec_instr_o(dec_instr_o), .x1_v_o(x1_v_o), .addr_gen_o(addr_gen_o),
		.rf_wr_x1_o(rf_wr_x1_o), .rf_wr_x2_o(rf_wr_x2_o), .rf_wr_x4_o(rf_wr_x4_o),
		.rf_wr_x5_o(rf_wr_x5_o), .dmem_send_o(dmem_send_o), .dmem_store_o(dmem_store_o),
		.dmem_access_o(dmem_access_o), .ld_return_o(ld_return_o), .sat_flag_o(sat_flag_o));
	fpps_pmem i_fpps_pmem (.mclk_i(mclk_i), .rst_i(rst_i), .fetch_addr_i(fetch_addr_o),
		.fetch_req_i(fetch_req_o), .fetch_hold_i(fetch_hold_o),
		.fetch_packet_o(fetch_packet_i));
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	function automatic logic [31:0] ins(fpps_cls_t c, logic [2:0] u, logic p);
		return {25'h0, u, c, p};
	endfunction
	task give_verdict();
		if (err_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 2000) begin
			err_count++;
			give_verdict();
		end
	end
	task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task wait_req(input logic [31:0] a);
		int n;
		n = 0;
		while (!(fetch_req_o === 1'b1 && fetch_hold_o === 1'b0 && fetch_addr_o === a)
			&& n < 200) begin
			step(1);
			n++;
		end
		chk(fetch_addr_o, a, "fetch request missing");
	endtask
	task do_reset();
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		chk({fetch_req_o, fetch_hold_o, sat_flag_o, fetch_addr_o}, 0, "reset state");
		chk({x1_v_o, dec_v_o, rf_wr_x5_o, dmem_send_o}, 0, "reset strobes");
		step(1);
		chk({dispatch_v_o, ld_return_o}, 0, "cycle two quiet");
		chk({fetch_req_o, fetch_addr_o}, {1'b1, 32'h0}, "first request");
	endtask
	task s_full();
		wait_req(32'h0);
		step(1);
		chk(fetch_addr_o, 32'h20, "next packet address");
		step(2);
		chk({dispatch_v_o, fetch_hold_o}, 2'b10, "one group dispatched");
		step(1);
		chk(dec_v_o, 8'hff, "decode all units");
		chk(dec_instr_o[5], ins(CLS_SINGLE, 3'h5, 1'b1), "decoded word");
		step(1);
		chk({x1_v_o, rf_wr_x1_o}, 16'hffff, "execute one writes");
		chk(fetch_addr_o, 32'ha0, "n+5 in send");
	endtask
	task s_classes();
		wait_req(32'h180);
		step(4);
		@(posedge mclk_i);
		sat_i <= 8'h20;
		#1;
		chk(x1_v_o, 8'h2f, "no-op not routed");
		chk(addr_gen_o, 8'h03, "address generation");
		chk(rf_wr_x1_o & 8'h2c, 8'h20, "single write only");
		@(posedge mclk_i);
		sat_i <= 8'h08;
		#1;
		chk({dmem_send_o, dmem_store_o}, 16'h0301, "data memory send");
		chk({rf_wr_x2_o, sat_flag_o}, 9'h008, "short multiply write");
		@(posedge mclk_i);
		sat_i <= 8'h00;
		#1;
		chk({dmem_access_o, sat_flag_o}, 9'h007, "access and flag");
		step(1);
		chk({ld_return_o, rf_wr_x4_o}, 16'h0208, "load return");
		step(1);
		chk(rf_wr_x5_o, 8'h02, "load write");
	endtask
	task s_pred_false();
		@(posedge mclk_i);
		sat_clr_i <= 1'b1;
		@(posedge mclk_i);
		sat_clr_i <= 1'b0;
		#1;
		chk(sat_flag_o, 1'b0, "flag cleared");
		wait_req(32'h300);
		step(4);
		@(posedge mclk_i);
		pred_i <= 8'hf4;
		#1;
		chk(rf_wr_x1_o & 8'h0b, 8'h00, "killed in execute one");
		@(posedge mclk_i);
		pred_i <= 8'hff;
		sat_i <= 8'h04;
		#1;
		chk({dmem_send_o, rf_wr_x2_o}, 16'h0004, "killed send");
		@(posedge mclk_i);
		sat_i <= 8'h00;
		#1;
		chk({dmem_access_o, sat_flag_o}, 9'h000, "killed access");
		step(1);
		chk({ld_return_o, sat_flag_o}, 9'h001, "multiply saturation");
		step(1);
		chk(rf_wr_x5_o, 8'h00, "killed load write");
	endtask
	task s_split();
		wait_req(32'h480);
		step(3);
		chk({dispatch_v_o, fetch_hold_o}, 2'b11, "split holds fetch");
		step(1);
		chk({dec_v_o, fetch_hold_o}, 9'h002, "first group decode");
		chk(fetch_addr_o, 32'h4e0, "fetch frozen");
		step(1);
		chk({dec_v_o, x1_v_o}, 16'hfe01, "second group follows");
		step(1);
		chk(x1_v_o, 8'hfe, "second group executes");
	endtask
	task s_branch();
		wait_req(32'h580);
		step(6);
		chk(fetch_addr_o, 32'h100, "branch target sent");
		step(1);
		chk(fetch_addr_o, 32'h120, "sequential after target");
	endtask
	initial begin
		for (int i = 0; i < 64; i++) begin
			// Filler packets of parallel no-operations keep the pipeline full
			i_fpps_pmem.prog[i] = {`FPPS_SLOTS{32'h0000_0001}};
		end
		for (int s = 0; s < 8; s++) begin
			i_fpps_pmem.prog[0][s] = ins(CLS_SINGLE, 3'(s), 1'b1);
			i_fpps_pmem.prog[36][s] = ins(CLS_SINGLE, 3'(s), s != 0);
		end
		i_fpps_pmem.prog[12] = {ins(CLS_NO_OPERATION, 3'h7, 1'b0),
			ins(CLS_NO_OPERATION, 3'h6, 1'b1), ins(CLS_SINGLE, 3'h5, 1'b1),
			ins(CLS_NO_OPERATION, 3'h4, 1'b1), ins(CLS_MULX, 3'h3, 1'b1),
			ins(CLS_MUL16, 3'h2, 1'b1), ins(CLS_LOAD, 3'h1, 1'b1), ins(CLS_STORE, 3'h0, 1'b1)};
		i_fpps_pmem.prog[24][3:0] = {ins(CLS_STORE, 3'h3, 1'b0), ins(CLS_SINGLE, 3'h0, 1'b1),
			ins(CLS_LOAD, 3'h1, 1'b1), ins(CLS_MUL16, 3'h2, 1'b1)};
		i_fpps_pmem.prog[44][0] = ins(CLS_BRANCH, 3'h0, 1'b0);
		do_reset();
		s_full();
		s_classes();
		s_pred_false();
		s_split();
		s_branch();
		do_reset();
		s_full();
		give_verdict();
	end
endmodule
